//--- peg_counter.sv
// top of the pulse event gate counter: apb register slave, 8-bit
// accumulator, wrap and input-edge flags with their request outputs.
// assumes an apb master on ref_clk and an asynchronous accumulator pin.
`timescale 1ns/1ns
`default_nettype none

module peg_counter #(
    parameter int TICK_DIV = peg_pkg::TICK_DIV  // gated-mode time base
) (
    // clock, reset, clock enable
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [peg_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [peg_pkg::DATA_W-1:0]   pwdata,
    output logic      [peg_pkg::DATA_W-1:0]   prdata,
    output logic                              pready,
    output logic                              pslverr,
    // accumulator pin
    input  wire logic                         accum_input_pin,
    // requests and function selects
    output logic                              count_wrap_irq,
    output logic                              input_edge_irq,
    output logic                              fourth_input_capture_en,
    output logic                              fifth_output_compare_en
);
    import peg_pkg::*;

    // --------------------------------------------------------------------
    // declarations
    // --------------------------------------------------------------------
    peg_pin_if pin ();                        // conditioned pin
    logic                tick;                // divide-by-N time base

    logic                en_r,     en_nxt;    // accum_enable
    peg_mode_t           mode_r,   mode_nxt;  // accum_mode_sel
    logic                edge_r,   edge_nxt;  // edge_level_sel
    logic                sel_r,    sel_nxt;   // capture4_compare5_sel
    logic                wirq_r,   wirq_nxt;  // count_wrap_irq_en
    logic                eirq_r,   eirq_nxt;  // input_edge_irq_en
    logic                wflag_r,  wflag_nxt; // count_wrap_flag
    logic                eflag_r,  eflag_nxt; // input_edge_flag
    logic [CNT_W-1:0]    count_r,  count_nxt; // accumulator_count, no reset
    logic [DATA_W-1:0]   rdata_r,  rdata_nxt; // registered read data
    logic                seen_r,   seen_nxt;  // setup phase taken

    logic                acc;                 // transfer completes this edge
    logic                wr;                  // write completes this edge
    logic                mapped;              // address hits a register
    logic                sel_edge;            // selected pin edge
    logic                gate_open;           // gated mode pin active
    logic                inc;                 // accumulator advances
    logic                wrap;                // advance from all ones
    logic [DATA_W-1:0]   rd_mux;              // value at paddr

    // --------------------------------------------------------------------
    // pin conditioning and time base
    // --------------------------------------------------------------------
    // two flops before any logic; the source must itself change no faster than clock/2
    peg_pin_sync u_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .ce        (ce),
        .pin_async (accum_input_pin),
        .pin_o     (pin)
    );

    peg_tick_div #(
        .DIV (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .tick    (tick)
    );

    // --------------------------------------------------------------------
    // apb decode
    // --------------------------------------------------------------------
    // ready waits one taken setup phase so read data is always fresh
    assign pready  = ce & seen_r;
    assign acc     = psel & penable & pready;
    assign wr      = acc & pwrite;
    assign mapped  = (paddr == OFF_CTRL) || (paddr == OFF_COUNT) ||
                     (paddr == OFF_MASK2) || (paddr == OFF_FLAG2);
    assign pslverr = psel & penable & pready & ~mapped;

    // read mux, unused bits read zero
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            OFF_CTRL: begin
                rd_mux[CTL_EN_BIT]   = en_r;
                rd_mux[CTL_MODE_BIT] = mode_r;
                rd_mux[CTL_EDGE_BIT] = edge_r;
                rd_mux[CTL_SEL_BIT]  = sel_r;
            end
            OFF_COUNT: begin
                rd_mux[CNT_W-1:0]    = count_r;
            end
            OFF_MASK2: begin
                rd_mux[WRAP_BIT]     = wirq_r;
                rd_mux[EDGE_BIT]     = eirq_r;
            end
            OFF_FLAG2: begin
                rd_mux[WRAP_BIT]     = wflag_r;
                rd_mux[EDGE_BIT]     = eflag_r;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // --------------------------------------------------------------------
    // accumulator datapath
    // --------------------------------------------------------------------
    // one edge select serves both modes: in gated mode the selected edge
    // is the one that closes the gate
    always_comb begin
        sel_edge  = en_r & (edge_r ? pin.rise : pin.fall);
        // the gate is open while the pin differs from the inhibit level
        gate_open = pin.level ^ edge_r;
        unique case (mode_r)
            PEG_MODE_EVENT: inc = en_r & sel_edge;
            PEG_MODE_GATED: inc = en_r & tick & gate_open;
        endcase
        wrap = inc & (count_r == {CNT_W{1'b1}});
    end

    // --------------------------------------------------------------------
    // next state of registers, flags and count
    // --------------------------------------------------------------------
    always_comb begin
        en_nxt    = en_r;
        mode_nxt  = mode_r;
        edge_nxt  = edge_r;
        sel_nxt   = sel_r;
        wirq_nxt  = wirq_r;
        eirq_nxt  = eirq_r;
        // software write one clears, hardware set wins the same cycle
        wflag_nxt = wflag_r;
        eflag_nxt = eflag_r;
        // count advances in its own phase, a register write overrides it
        count_nxt = inc ? count_r + 1'b1 : count_r;
        seen_nxt  = psel & ~acc;
        rdata_nxt = psel ? rd_mux : rdata_r;
        if (wr) begin
            unique case (paddr)
                OFF_CTRL: begin
                    en_nxt   = pwdata[CTL_EN_BIT];
                    mode_nxt = peg_mode_t'(pwdata[CTL_MODE_BIT]);
                    edge_nxt = pwdata[CTL_EDGE_BIT];
                    sel_nxt  = pwdata[CTL_SEL_BIT];
                end
                OFF_COUNT: begin
                    count_nxt = pwdata[CNT_W-1:0];
                end
                OFF_MASK2: begin
                    wirq_nxt = pwdata[WRAP_BIT];
                    eirq_nxt = pwdata[EDGE_BIT];
                end
                OFF_FLAG2: begin
                    if (pwdata[WRAP_BIT]) wflag_nxt = 1'b0;
                    if (pwdata[EDGE_BIT]) eflag_nxt = 1'b0;
                end
                default: begin
                    en_nxt = en_r;
                end
            endcase
        end
        if (wrap)     wflag_nxt = 1'b1;
        if (sel_edge) eflag_nxt = 1'b1;
    end

    // control state, flags and bus state take reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_r    <= RST_EN;
            mode_r  <= peg_mode_t'(RST_MODE);
            edge_r  <= RST_EDGE;
            sel_r   <= RST_SEL;
            wirq_r  <= RST_IRQEN;
            eirq_r  <= RST_IRQEN;
            wflag_r <= RST_FLAG;
            eflag_r <= RST_FLAG;
            seen_r  <= 1'b0;
            rdata_r <= '0;
        end else if (ce) begin
            en_r    <= en_nxt;
            mode_r  <= mode_nxt;
            edge_r  <= edge_nxt;
            sel_r   <= sel_nxt;
            wirq_r  <= wirq_nxt;
            eirq_r  <= eirq_nxt;
            wflag_r <= wflag_nxt;
            eflag_r <= eflag_nxt;
            seen_r  <= seen_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // the count keeps its contents through reset
    always_ff @(posedge ref_clk) begin
        if (ce) begin
            count_r <= count_nxt;
        end
    end

    // --------------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------------
    assign prdata                  = rdata_r;
    // enables gate only the requests, never the flags
    assign count_wrap_irq          = wflag_r & wirq_r;
    assign input_edge_irq          = eflag_r & eirq_r;
    // the pin is shared, so exactly one function owns it
    assign fourth_input_capture_en = sel_r;
    assign fifth_output_compare_en = ~sel_r;

    // --------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic wr_cnt;                             // count overwritten this edge
    assign wr_cnt = wr & (paddr == OFF_COUNT);

    // the count takes no reset, so it is unknown until first written;
    // the count checks wait for that write. reset clears this helper too,
    // a short blind spot traded for a helper that needs no initial value
    logic cnt_seen_r, cnt_seen_nxt;           // count holds a written value

    always_comb begin
        cnt_seen_nxt = cnt_seen_r | wr_cnt;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_seen_r <= 1'b0;
        end else if (ce) begin
            cnt_seen_r <= cnt_seen_nxt;
        end
    end

    AST_DISABLED_HOLDS: assert property (
        ce && cnt_seen_r && !en_r && !wr_cnt |=> count_r == $past(count_r) && !$rose(wflag_r))
        else $error("count moved while disabled");
    AST_EVENT_EDGE: assert property (
        ce && en_r && mode_r == PEG_MODE_EVENT && (edge_r ? pin.rise : pin.fall)
        && cnt_seen_r && !wr_cnt |=> count_r == $past(count_r) + 8'h01)
        else $error("selected edge did not count");
    AST_GATED_INHIBIT: assert property (
        ce && cnt_seen_r && en_r && mode_r == PEG_MODE_GATED && pin.level == edge_r
        && !wr_cnt |=> count_r == $past(count_r))
        else $error("count advanced at inhibit level");
    AST_GATED_TICK: assert property (
        ce && en_r && mode_r == PEG_MODE_GATED && tick && pin.level != edge_r
        && cnt_seen_r && !wr_cnt |=> count_r == $past(count_r) + 8'h01)
        else $error("gated tick did not count");
    AST_WRAP_SETS: assert property (
        ce && inc && count_r == 8'hff && !wr_cnt |=> wflag_r && count_r == 8'h00)
        else $error("wrap did not set flag");
    AST_WRAP_CLEAR: assert property (
        ce && wr && paddr == OFF_FLAG2 && pwdata[WRAP_BIT] && !wrap |=> !wflag_r)
        else $error("wrap flag not cleared");
    AST_EDGE_SET: assert property (
        ce && sel_edge |=> eflag_r ##1 (eflag_r || $past(wr)))
        else $error("edge flag not set");
    AST_EDGE_CLEAR: assert property (
        ce && wr && paddr == OFF_FLAG2 && pwdata[EDGE_BIT] && !sel_edge |=> !eflag_r)
        else $error("edge flag not cleared");
    AST_WRAP_IRQ: assert property (
        ce && wflag_r && wr && paddr == OFF_MASK2 && pwdata[WRAP_BIT] |=> count_wrap_irq)
        else $error("wrap request missing");
    AST_EDGE_IRQ: assert property (
        ce && eflag_r && wr && paddr == OFF_MASK2
        |=> eflag_r && input_edge_irq == $past(pwdata[EDGE_BIT]))
        else $error("edge enable disturbed flag or request");
    AST_SEL_ONE_HOT: assert property (
        ce && wr && paddr == OFF_CTRL |=> fourth_input_capture_en == $past(pwdata[CTL_SEL_BIT])
        && fourth_input_capture_en != fifth_output_compare_en)
        else $error("capture and compare select wrong");
    AST_COUNT_WRITE: assert property (
        ce && wr_cnt |=> count_r == $past(pwdata[7:0]))
        else $error("count write lost");

endmodule : peg_counter

`default_nettype wire

//--- peg_pkg.sv
// package of the pulse event gate counter: register map, field positions,
// reset values and the tick divider count.
// assumes a 32-bit apb with byte addresses and one register per aligned word.
`default_nettype none

package peg_pkg;

    // --------------------------------------------------------------------
    // bus geometry
    // --------------------------------------------------------------------
    localparam int ADDR_W = 8;                // apb address width
    localparam int DATA_W = 32;               // apb data width
    localparam int CNT_W  = 8;                // accumulator width

    // --------------------------------------------------------------------
    // register offsets (byte addresses)
    // --------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;  // accumulator_control
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;  // accumulator_count
    localparam logic [ADDR_W-1:0] OFF_MASK2 = 8'h08;  // timer_mask_two
    localparam logic [ADDR_W-1:0] OFF_FLAG2 = 8'h0c;  // timer_flags_two

    // --------------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------------
    localparam int CTL_EN_BIT   = 6;          // accum_enable
    localparam int CTL_MODE_BIT = 5;          // accum_mode_sel
    localparam int CTL_EDGE_BIT = 4;          // edge_level_sel
    localparam int CTL_SEL_BIT  = 2;          // capture4_compare5_sel
    localparam int WRAP_BIT     = 5;          // count_wrap flag and enable
    localparam int EDGE_BIT     = 4;          // input_edge flag and enable

    // --------------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------------
    localparam logic RST_EN    = 1'b0;        // accumulator off
    localparam logic RST_MODE  = 1'b0;        // event counting
    localparam logic RST_EDGE  = 1'b0;        // falling edge / low inhibits
    localparam logic RST_SEL   = 1'b0;        // compare 5 selected
    localparam logic RST_IRQEN = 1'b0;        // both requests masked
    localparam logic RST_FLAG  = 1'b0;        // both flags clear

    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int TICK_DIV = 64;             // gated-mode time base divider

    // counting mode of the accumulator
    typedef enum logic {
        PEG_MODE_EVENT = 1'b0,
        PEG_MODE_GATED = 1'b1
    } peg_mode_t;

endpackage : peg_pkg

`default_nettype wire

//--- peg_pin_if.sv
// interface carrying the conditioned accumulator input between the pin
// synchroniser and the counter core.
// assumes both ends run on ref_clk.
`timescale 1ns/1ns
`default_nettype none

interface peg_pin_if;
    logic level;                              // synchronised pin level
    logic rise;                               // one-cycle rising edge
    logic fall;                               // one-cycle falling edge

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : peg_pin_if

`default_nettype wire

//--- peg_pin_sync.sv
// two-flop synchroniser and edge detector for the accumulator input pin.
// assumes the pin is asynchronous to ref_clk and changes no faster than
// half the clock rate, otherwise edges merge and are lost.
`timescale 1ns/1ns
`default_nettype none

module peg_pin_sync (
    // clock and control
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ce,
    // raw pin
    input  wire logic pin_async,
    // conditioned pin
    peg_pin_if.src    pin_o
);
    import peg_pkg::*;

    logic meta_r,  meta_nxt;                  // first stage, read by sync only
    logic sync_r,  sync_nxt;                  // second stage, safe level
    logic last_r,  last_nxt;                  // previous safe level

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    always_comb begin
        meta_nxt = pin_async;
        sync_nxt = meta_r;
        last_nxt = sync_r;
    end

    // freezes with ce so an edge is never seen twice
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else if (ce) begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            last_r <= last_nxt;
        end
    end

    // edges come only from the second and third stage
    assign pin_o.level = sync_r;
    assign pin_o.rise  = sync_r & ~last_r;
    assign pin_o.fall  = ~sync_r & last_r;

endmodule : peg_pin_sync

`default_nettype wire

//--- peg_tick_div.sv
// free-running divider giving one tick every DIV enabled clocks.
// assumes it is never stopped except by reset or a low clock enable.
`timescale 1ns/1ns
`default_nettype none

module peg_tick_div #(
    parameter int DIV = peg_pkg::TICK_DIV     // clocks per tick
) (
    // clock and control
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic ce,
    // tick out
    output logic      tick
);
    import peg_pkg::*;

    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_r, cnt_nxt;             // position within the period
    logic         tick_r, tick_nxt;           // registered tick

    // --------------------------------------------------------------------
    // next state
    // --------------------------------------------------------------------
    always_comb begin
        tick_nxt = (cnt_r == LAST);
        cnt_nxt  = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end

    // not gated by the accumulator enable: the time base keeps running
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : peg_tick_div

`default_nettype wire

//--- peg_pin_src.sv
// pin source standing in for the outside event or gate signal.
// assumes the bench asks for levels on ref_clk; this model spaces them.
`timescale 1ns/1ns
`default_nettype none

module peg_pin_src (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // requested level and the driven pin
    input  wire logic want_lvl,
    output logic      pin
);
    logic [1:0] hold_r;                       // clocks since the last change

    // follow the request, one change per four clocks at most, so the
    // device never sees toggling above half its clock rate
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin    <= want_lvl;
            hold_r <= 2'h0;
        end else if (want_lvl != pin && hold_r == 2'h3) begin
            pin    <= want_lvl;
            hold_r <= 2'h0;
        end else if (hold_r != 2'h3) begin
            hold_r <= hold_r + 2'h1;
        end
    end
endmodule : peg_pin_src

`default_nettype wire

//--- pulse_event_gate_counter_test.sv
// self-checking bench of the pulse event gate counter over apb.
// assumes peg_pkg and the pin source model; ce is held high throughout.
`timescale 1ns/1ns
`default_nettype none

module pulse_event_gate_counter_test;
    import peg_pkg::*;
    localparam int TDIV = 4;                  // short time base keeps runs brief
    logic              ref_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;                 // apb address
    logic [DATA_W-1:0] pwdata, prdata;        // apb data
    logic              want_lvl, accum_input_pin, count_wrap_irq, input_edge_irq;
    logic              fourth_input_capture_en, fifth_output_compare_en;
    int                num_errors = 0, n_checks = 0, cyc = 0, seed = 86;

    peg_counter #(.TICK_DIV(TDIV)) dut_u (.ref_clk, .rst, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .accum_input_pin,
        .count_wrap_irq, .input_edge_irq, .fourth_input_capture_en,
        .fifth_output_compare_en);
    peg_pin_src pin_u (.ref_clk, .rst, .want_lvl, .pin(accum_input_pin));

    // clock and hang guard
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; waits on pready, values seen are those before the edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // only the bench timeout ends a wait that never gets its answer
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask : rd

    // pin level change, long enough for the synchroniser to pass it
    task automatic set_pin(input logic v);
        want_lvl <= v;
        repeat (8) @(posedge ref_clk);
    endtask : set_pin

    task automatic pulses(input logic e, input int n);
        for (int i = 0; i < n; i++) begin
            set_pin(e);
            set_pin(~e);
        end
    endtask : pulses

    function automatic logic [31:0] ctl(input logic en, md, ed, sl);
        ctl = 32'h0;
        ctl[CTL_EN_BIT]   = en;
        ctl[CTL_MODE_BIT] = md;
        ctl[CTL_EDGE_BIT] = ed;
        ctl[CTL_SEL_BIT]  = sl;
    endfunction : ctl

    function automatic logic [31:0] flags(input logic w, input logic ed);
        flags = 32'h0;
        flags[WRAP_BIT] = w;
        flags[EDGE_BIT] = ed;
    endfunction : flags

    // main sequence
    initial begin
        logic [31:0] q, r;
        logic        e2;
        logic [7:0]  st;
        logic [8:0]  sum;
        int          n;
        {ref_clk, ce, psel, penable, pwrite, want_lvl} = 6'h10;
        rst = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_MASK2, 32'h0);
        rd(OFF_FLAG2, 32'h0);
        chk({fourth_input_capture_en, fifth_output_compare_en}, 32'h1);
        apb(1'b0, 8'h10, 32'h0, q, e2);
        chk({e2, q[30:0]}, 32'h80000000);
        wr(OFF_CTRL, ctl(0, 0, 0, 1));
        @(negedge ref_clk);
        chk({fourth_input_capture_en, fifth_output_compare_en}, 32'h2);
        r = $random(seed);
        wr(OFF_COUNT, r);
        rd(OFF_COUNT, {24'h0, r[7:0]});
        // mid-run reset clears control but must keep the count
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd(OFF_COUNT, {24'h0, r[7:0]});
        rd(OFF_CTRL, 32'h0);
        // event counting on either edge, ending near or across the wrap
        for (int e = 0; e < 2; e++) begin
            r = $random(seed);
            st = (e == 1) ? 8'hfc + r[1:0] : 8'hff;
            n = (e == 1) ? 1 + r[3:2] : 1;
            sum = st + n;
            wr(OFF_CTRL, 32'h0);
            set_pin(~e[0]);
            wr(OFF_COUNT, st);
            wr(OFF_FLAG2, 32'h30);
            wr(OFF_MASK2, 32'h0);
            wr(OFF_CTRL, ctl(1, 0, e[0], 0));
            pulses(e[0], n);
            rd(OFF_COUNT, sum[7:0]);
            rd(OFF_FLAG2, flags(sum[8], 1));
            @(negedge ref_clk);
            chk({count_wrap_irq, input_edge_irq}, 32'h0);
            wr(OFF_MASK2, 32'h30);
            @(negedge ref_clk);
            chk({count_wrap_irq, input_edge_irq}, {sum[8], 1'b1});
            wr(OFF_FLAG2, 32'h0);
            rd(OFF_FLAG2, flags(sum[8], 1));
            wr(OFF_FLAG2, 32'h20);
            rd(OFF_FLAG2, flags(0, 1));
            wr(OFF_FLAG2, 32'h10);
            rd(OFF_FLAG2, 32'h0);
            wr(OFF_CTRL, ctl(0, 0, e[0], 0));
            pulses(e[0], 2);
            rd(OFF_COUNT, sum[7:0]);
            rd(OFF_FLAG2, 32'h0);
        end
        // gated accumulation: held while inhibited, ticks while open
        for (int e = 0; e < 2; e++) begin
            wr(OFF_CTRL, 32'h0);
            set_pin(e[0]);
            wr(OFF_COUNT, 32'h0);
            wr(OFF_CTRL, ctl(1, 1, e[0], 0));
            repeat (40) @(posedge ref_clk);
            rd(OFF_COUNT, 32'h0);
            set_pin(~e[0]);
            repeat (36) @(posedge ref_clk);
            apb(1'b0, OFF_COUNT, 32'h0, q, e2);
            chk(q >= 8 && q <= 12, 32'h1);
        end
        complete_run();
    end
endmodule : pulse_event_gate_counter_test

`default_nettype wire
